// File: pcd_defs.vh
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH
// Clock rate in MHz
`define PCD_CLK_MHZ 25
// Opcodes, upper nibble of the first byte
`define PCD_OP_SEL 4'h3
`define PCD_OP_PLAY 4'h4
`define PCD_OP_START 4'h5
`define PCD_OP_STOP 4'h6
`define PCD_OP_SIL 4'h7
`define PCD_OP_REP_SET 4'h8
`define PCD_OP_REP_CLR 4'h9
// Whole power-down byte
`define PCD_PD_BYTE 8'h20
// Power-down processing time in us and its cycle count (exact product)
`define PCD_PD_TIME_US 10
`define PCD_PD_CYC (`PCD_PD_TIME_US * `PCD_CLK_MHZ)
// Silence step in us and its cycle count
`define PCD_SIL_STEP_US 4000
`define PCD_SIL_STEP_CYC (`PCD_SIL_STEP_US * `PCD_CLK_MHZ)
`endif

// File: pcd_decoder.v
// Behaviour
// R1 - Power-down ignored while any channel busy
// R2 - Power-down enters sleep, clears all settings
// R3 - Oscillator stops after power-down processing time
// R4 - Phrase-select: two bytes, stores channel phrase
// R5 - Ten-bit phrase reaches 0 to 1023
// R6 - Channel code 00..11 selects channel 0..3
// R7 - Play: two bytes, selects and plays
// R8 - Start: mask byte plays selected phrases
// R9 - Host selects phrase, sends when accept high
// R10 - All-zero channel mask command is ignored
// R11 - Stop halts masked channels, flags go high
// R12 - Stop accepted regardless of accept flag
// R13 - Host waits, checks busy, repeats stop
// R14 - Silence-insert: mask byte plus count byte
// R15 - Silence lasts (count+1) times 4ms
// R16 - Host programs silence count at least 04h
// R17 - Repeat never applies to inserted silence
// R18 - Repeat-set enables repeat on masked channels
// R19 - Repeat replays until cancelled or stopped
// R20 - Repeat-cancel drives accept flag high when nothing is queued
// R21 - Accept low while queued item is pending
// R22 - Second byte follows first, uses its opcode
`timescale 1ns/1ps
`include "pcd_defs.vh"
module pcd_decoder
#(
  parameter SIL_STEP_CYC = `PCD_SIL_STEP_CYC,
  parameter PD_CYC = `PCD_PD_CYC,
  parameter SIL_W = 17,
  parameter PD_W = 16
)
(
  input wire SYS_CLK, // System clock
  input wire SRST, // Synchronous reset
  input wire CE, // Clock enable
  input wire CMD_VALID, // Command byte strobe
  input wire [7:0] CMD_BYTE, // Command byte
  input wire [3:0] PHRASE_END, // Engine finished phrase, per channel
  output reg [3:0] PLAY_GO, // Start phrase pulse, per channel
  output reg [39:0] PLAY_PHRASE, // Phrase number, 10 bits per channel
  output reg [3:0] PLAY_HALT, // Halt pulse, per channel
  output reg [3:0] SILENCE_ON, // Silence running, per channel
  output reg [3:0] REPEAT_ON, // Repeat enabled, per channel
  output reg [3:0] COMMAND_ACCEPT_FLAG, // Channel takes queued commands
  output reg [3:0] CHANNEL_BUSY_N, // Channel busy, active low
  output reg POWER_DOWN, // Power-down state
  output reg OSC_STOP // Oscillator stop request
);

  // ********************************
  // Byte assembly and decode
  // ********************************
  reg have_first;
  reg [7:0] first;
  wire [3:0] op1 = CMD_BYTE[7:4];
  wire is_two = (op1 == `PCD_OP_SEL) || (op1 == `PCD_OP_PLAY) || (op1 == `PCD_OP_SIL);
  wire live = CE & CMD_VALID & ~POWER_DOWN;
  wire v1 = live & ~have_first;
  wire v2 = live & have_first;
  wire [3:0] mask1 = CMD_BYTE[3:0];
  wire mask1_ok = |mask1; // see R10
  wire mask2_ok = |first[3:0]; // see R10
  wire [3:0] code_ch = 4'h1 << first[1:0]; // see R6
  wire [9:0] new_phrase = {first[3:2], CMD_BYTE}; // see R4 see R5
  wire [3:0] do_sel = (v2 && first[7:4] == `PCD_OP_SEL) ? code_ch : 4'h0; // see R4
  wire [3:0] do_play = (v2 && first[7:4] == `PCD_OP_PLAY) ? code_ch : 4'h0; // see R7
  wire [3:0] do_sil = (v2 && first[7:4] == `PCD_OP_SIL && mask2_ok) ? first[3:0] : 4'h0; // see R14
  wire [3:0] do_start = (v1 && op1 == `PCD_OP_START && mask1_ok) ? mask1 : 4'h0; // see R8
  wire [3:0] do_stop = (v1 && op1 == `PCD_OP_STOP && mask1_ok) ? mask1 : 4'h0; // see R11 see R12
  wire [3:0] do_rep = (v1 && op1 == `PCD_OP_REP_SET && mask1_ok) ? mask1 : 4'h0; // see R18
  wire [3:0] do_cancel = (v1 && op1 == `PCD_OP_REP_CLR && mask1_ok) ? mask1 : 4'h0;
  wire do_pd = v1 && CMD_BYTE == `PCD_PD_BYTE && (&CHANNEL_BUSY_N); // see R1

  always @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      have_first <= 1'b0;
      first <= 8'h00;
    end
    else if (CE)
    begin
      if (POWER_DOWN)
        have_first <= 1'b0;
      else if (v2)
        have_first <= 1'b0; // see R22
      else if (v1 && is_two)
      begin
        have_first <= 1'b1; // see R22
        first <= CMD_BYTE;
      end
    end
  end

  // ********************************
  // Power-down sequencing
  // ********************************
  reg [PD_W-1:0] pd_cnt;

  always @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      POWER_DOWN <= 1'b0;
      OSC_STOP <= 1'b0;
      pd_cnt <= {PD_W{1'b0}};
    end
    else if (CE)
    begin
      if (do_pd)
      begin
        POWER_DOWN <= 1'b1; // see R2
        pd_cnt <= PD_CYC[PD_W-1:0] - 1'b1;
      end
      else if (POWER_DOWN && !OSC_STOP)
      begin
        if (pd_cnt == {PD_W{1'b0}})
          OSC_STOP <= 1'b1; // see R3
        else
          pd_cnt <= pd_cnt - 1'b1;
      end
    end
  end

  // ********************************
  // Per-channel sequencing
  // ********************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      reg playing;
      reg pend;
      reg pend_sil;
      reg [9:0] pend_data;
      reg [9:0] sel_phrase;
      reg [9:0] cur_phrase;
      reg [8:0] sil_ticks;
      reg [SIL_W-1:0] sil_pre;
      wire active = playing | SILENCE_ON[g];
      wire sil_done = SILENCE_ON[g] && sil_pre == {SIL_W{1'b0}} && sil_ticks == 9'h000;

      always @(posedge SYS_CLK)
      begin
        if (SRST || (CE && do_pd))
        begin
          // see R2
          playing <= 1'b0;
          pend <= 1'b0;
          pend_sil <= 1'b0;
          pend_data <= 10'h000;
          sel_phrase <= 10'h000;
          cur_phrase <= 10'h000;
          sil_ticks <= 9'h000;
          sil_pre <= {SIL_W{1'b0}};
          SILENCE_ON[g] <= 1'b0;
          REPEAT_ON[g] <= 1'b0;
          PLAY_GO[g] <= 1'b0;
          PLAY_HALT[g] <= 1'b0;
          PLAY_PHRASE[g*10 +: 10] <= 10'h000;
          COMMAND_ACCEPT_FLAG[g] <= 1'b1;
          CHANNEL_BUSY_N[g] <= 1'b1;
        end
        else if (CE)
        begin
          PLAY_GO[g] <= 1'b0;
          PLAY_HALT[g] <= 1'b0;
          COMMAND_ACCEPT_FLAG[g] <= ~(pend | (REPEAT_ON[g] & playing)); // see R21
          CHANNEL_BUSY_N[g] <= ~(active | pend);
          if (do_sel[g])
            sel_phrase <= new_phrase; // see R4
          if (do_stop[g])
          begin
            playing <= 1'b0; // see R11
            pend <= 1'b0;
            SILENCE_ON[g] <= 1'b0;
            REPEAT_ON[g] <= 1'b0; // see R19
            PLAY_HALT[g] <= 1'b1;
            COMMAND_ACCEPT_FLAG[g] <= 1'b1; // see R11
            CHANNEL_BUSY_N[g] <= 1'b1; // see R11
          end
          else
          begin
            if (do_cancel[g])
            begin
              REPEAT_ON[g] <= 1'b0;
              COMMAND_ACCEPT_FLAG[g] <= ~pend; // see R20
            end
            else if (do_rep[g])
              REPEAT_ON[g] <= 1'b1; // see R18
            // Requests queue into a single slot
            if (do_play[g])
            begin
              pend <= 1'b1; // see R7
              pend_sil <= 1'b0;
              pend_data <= new_phrase;
            end
            else if (do_start[g])
            begin
              pend <= 1'b1; // see R8 see R9
              pend_sil <= 1'b0;
              pend_data <= sel_phrase;
            end
            else if (do_sil[g])
            begin
              pend <= 1'b1; // see R14
              pend_sil <= 1'b1;
              pend_data <= {2'b00, CMD_BYTE};
            end
            // End of phrase: repeat unless something is queued
            if (playing && PHRASE_END[g])
            begin
              if (REPEAT_ON[g] && !pend && !do_cancel[g])
                PLAY_GO[g] <= 1'b1; // see R19
              else
                playing <= 1'b0;
            end
            // Silence timer, (count+1) steps, never repeated
            if (SILENCE_ON[g])
            begin
              if (sil_done)
                SILENCE_ON[g] <= 1'b0; // see R17
              else if (sil_pre == {SIL_W{1'b0}})
              begin
                sil_ticks <= sil_ticks - 1'b1;
                sil_pre <= SIL_STEP_CYC[SIL_W-1:0] - 1'b1;
              end
              else
                sil_pre <= sil_pre - 1'b1;
            end
            // Launch queued item once the channel is idle
            if (!active && pend && !do_play[g] && !do_start[g] && !do_sil[g])
            begin
              pend <= 1'b0;
              if (pend_sil)
              begin
                SILENCE_ON[g] <= 1'b1; // see R15
                sil_ticks <= {1'b0, pend_data[7:0]};
                sil_pre <= SIL_STEP_CYC[SIL_W-1:0] - 1'b1;
              end
              else
              begin
                playing <= 1'b1;
                cur_phrase <= pend_data;
                PLAY_PHRASE[g*10 +: 10] <= pend_data;
                PLAY_GO[g] <= 1'b1;
              end
            end
          end
        end
      end
    end
  endgenerate

endmodule

// File: pcd_sva.sv
`timescale 1ns/1ps
module pcd_sva #(parameter PD_CYC = 5)
(
  input wire SYS_CLK, // Clock
  input wire SRST, // Reset
  input wire CE, // Enable
  input wire CMD_VALID, // Strobe
  input wire [7:0] CMD_BYTE, // Byte
  input wire [3:0] PLAY_GO, // Go
  input wire [3:0] PLAY_HALT, // Halt
  input wire [3:0] COMMAND_ACCEPT_FLAG, // Accept
  input wire [3:0] CHANNEL_BUSY_N, // Busy
  input wire POWER_DOWN, // Sleep
  input wire OSC_STOP // Osc off
);
  localparam int PDA = PD_CYC - 1;
  localparam int PDB = PD_CYC + 1;
  reg sec, stop_q;
  reg [3:0] mask_q;
  wire tk = CE && CMD_VALID && !POWER_DOWN;
  wire first = tk && !sec;
  wire pd = first && CMD_BYTE == 8'h20;
  // Marks the byte after a two-byte opcode
  always @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      sec <= 1'b0;
      stop_q <= 1'b0;
    end
    else
    begin
      if (tk)
        sec <= first && CMD_BYTE[7:4] inside {4'h3, 4'h4, 4'h7};
      stop_q <= first && CMD_BYTE[7:4] == 4'h6;
    end
    mask_q <= CMD_BYTE[3:0];
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  chk_stop_halt: assert property (stop_q |-> (PLAY_HALT & mask_q) == mask_q)
    else $error("halt missing");
  chk_stop_flags: assert property (stop_q |-> (COMMAND_ACCEPT_FLAG & CHANNEL_BUSY_N & mask_q) == mask_q)
    else $error("stop flags low");
  chk_halt_cause: assert property (PLAY_HALT != 4'h0 |-> stop_q && (PLAY_HALT & ~mask_q) == 4'h0)
    else $error("stray halt");
  chk_pd_busy: assert property (pd && CHANNEL_BUSY_N != 4'hf |=> !POWER_DOWN)
    else $error("sleep while busy");
  chk_pd_enter: assert property (pd && CHANNEL_BUSY_N == 4'hf |=> POWER_DOWN)
    else $error("sleep missed");
  chk_pd_hold: assert property (POWER_DOWN |=> POWER_DOWN && PLAY_GO == 4'h0 && COMMAND_ACCEPT_FLAG == 4'hf)
    else $error("sleep left");
  chk_osc_early: assert property ($rose(POWER_DOWN) |-> !OSC_STOP [*3])
    else $error("osc stop early");
  chk_osc_late: assert property ($rose(POWER_DOWN) |-> ##[PDA:PDB] OSC_STOP)
    else $error("osc stop late");
  chk_go_busy: assert property ((PLAY_GO & CHANNEL_BUSY_N) == 4'h0)
    else $error("go while not busy");
endmodule
bind pcd_decoder pcd_sva #(.PD_CYC(PD_CYC)) pcd_sva_i (.SYS_CLK(SYS_CLK), .SRST(SRST), .CE(CE),
  .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE), .PLAY_GO(PLAY_GO), .PLAY_HALT(PLAY_HALT),
  .COMMAND_ACCEPT_FLAG(COMMAND_ACCEPT_FLAG), .CHANNEL_BUSY_N(CHANNEL_BUSY_N),
  .POWER_DOWN(POWER_DOWN), .OSC_STOP(OSC_STOP));

// File: pcd_engine.sv
`timescale 1ns/1ps
// Playback engine: ends each phrase LEN cycles after its start
module pcd_engine #(parameter LEN = 30)
(
  input wire SYS_CLK, // Clock
  input wire SRST, // Reset
  input wire [3:0] PLAY_GO, // Start
  input wire [3:0] PLAY_HALT, // Halt
  output reg [3:0] PHRASE_END // Done
);
  reg [7:0] cnt [0:3];
  integer i;
  always @(posedge SYS_CLK)
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      PHRASE_END[i] <= 1'b0;
      if (SRST || PLAY_HALT[i])
        cnt[i] <= 8'h00;
      else if (PLAY_GO[i])
        cnt[i] <= LEN;
      else if (cnt[i] != 8'h00)
      begin
        cnt[i] <= cnt[i] - 8'h01;
        PHRASE_END[i] <= cnt[i] == 8'h01;
      end
    end
  end
endmodule

// File: playback_command_decoder_tb_top.sv
`timescale 1ns/1ps
module playback_command_decoder_tb_top;
  localparam SIL = 10;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg cmd_valid = 1'b0;
  reg ce = 1'b1;
  reg [7:0] cmd_byte = 8'h00;
  wire [3:0] phrase_end, play_go, play_halt, silence_on, repeat_on, accept, busy_n;
  wire [39:0] play_phrase;
  wire power_down, osc_stop;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer k;
  pcd_decoder #(.SIL_STEP_CYC(SIL), .PD_CYC(5)) pcd_decoder_i (.SYS_CLK(sys_clk), .SRST(srst), .CE(ce),
    .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte), .PHRASE_END(phrase_end), .PLAY_GO(play_go),
    .PLAY_PHRASE(play_phrase), .PLAY_HALT(play_halt), .SILENCE_ON(silence_on), .REPEAT_ON(repeat_on),
    .COMMAND_ACCEPT_FLAG(accept), .CHANNEL_BUSY_N(busy_n), .POWER_DOWN(power_down), .OSC_STOP(osc_stop));
  pcd_engine #(.LEN(30)) pcd_engine_i (.SYS_CLK(sys_clk), .SRST(srst), .PLAY_GO(play_go),
    .PLAY_HALT(play_halt), .PHRASE_END(phrase_end));
  initial forever #20 sys_clk = ~sys_clk;
  task conclude;
  begin
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  task chk(input string w, input [39:0] s, input [39:0] e);
  begin
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s exp %0h seen %0h", w, e, s);
    end
  end
  endtask
  // One byte per strobe; the bus shows the inverse once released
  task send(input [7:0] b);
  begin
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_byte = ~b;
  end
  endtask
  task wait_go(input integer ch);
  begin
    k = 0;
    while (play_go[ch] !== 1'b1 && k < 200)
    begin
      @(negedge sys_clk);
      k = k + 1;
    end
  end
  endtask
  task idle;
  begin
    k = 0;
    while (busy_n !== 4'hf && k < 500)
    begin
      @(negedge sys_clk);
      k = k + 1;
    end
  end
  endtask
  initial
  begin
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    chk("flags", {accept, busy_n}, 8'hff);
    chk("phrase", play_phrase, 40'h0);
    $display("test reset done");
    send(8'h4e);
    send(8'hff);
    wait_go(2);
    chk("phrase ch2", play_phrase[29:20], 10'h3ff);
    send(8'h20);
    chk("sleep busy", power_down, 1'b0);
    send(8'h64);
    chk("stop ch2", {accept[2], busy_n[2]}, 2'b11);
    $display("test play stop done");
    send(8'h31);
    send(8'h01);
    send(8'h50);
    repeat (3) @(negedge sys_clk);
    chk("zero mask", busy_n[1], 1'b1);
    send(8'h52);
    wait_go(1);
    chk("phrase ch1", play_phrase[19:10], 10'h001);
    $display("test start done");
    send(8'h71);
    send(8'h04);
    k = 0;
    while (silence_on[0] !== 1'b1 && k < 20)
    begin
      @(negedge sys_clk);
      k = k + 1;
    end
    k = 0;
    while (silence_on[0] === 1'b1 && k < 200)
    begin
      @(negedge sys_clk);
      k = k + 1;
    end
    chk("silence len", k, (4 + 1) * SIL);
    $display("test silence done");
    idle;
    send(8'h81);
    send(8'h40);
    send(8'h03);
    wait_go(0);
    @(negedge sys_clk);
    wait_go(0);
    chk("repeat", {repeat_on[0], play_phrase[9:0]}, 11'h403);
    send(8'h91);
    @(negedge sys_clk);
    chk("cancel", {repeat_on[0], accept[0]}, 2'b01);
    idle;
    $display("test repeat done");
    // Clock enable low: a start byte must not be taken
    @(negedge sys_clk);
    ce = 1'b0;
    send(8'h52);
    repeat (3) @(negedge sys_clk);
    chk("frozen", busy_n, 4'hf);
    ce = 1'b1;
    $display("test enable done");
    send(8'h20);
    repeat (8) @(negedge sys_clk);
    chk("sleep", {power_down, osc_stop, accept}, 6'h3f);
    send(8'h40);
    send(8'h05);
    repeat (3) @(negedge sys_clk);
    chk("asleep", busy_n, 4'hf);
    $display("test sleep done");
    // Mid-run reset leaves power-down; a play must work right after
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    chk("wake", {power_down, osc_stop, accept}, 6'h0f);
    send(8'h40);
    send(8'h07);
    wait_go(0);
    chk("phrase after reset", play_phrase[9:0], 10'h007);
    $display("test reset again done");
    conclude;
  end
endmodule
